// File: common/sshcd_pkg.sv
package sshcd_pkg;

  // ****************************************************************
  // command opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_LEAVE_MASK  = 8'hF6;
  localparam logic [7:0] OPC_LEAVE_BASE  = 8'h92;
  localparam logic [7:0] OPC_RET_ZERO    = 8'h70;
  localparam logic [7:0] OPC_GO_MARK     = 8'h78;
  localparam logic [7:0] OPC_CLEAR_POS   = 8'hD8;
  localparam logic [7:0] OPC_REINIT      = 8'hC0;
  localparam logic [7:0] OPC_RAMP_HALT   = 8'hB0;
  localparam logic [7:0] OPC_ABR_HALT    = 8'hB8;
  localparam logic [7:0] OPC_RAMP_FLOAT  = 8'hA0;
  localparam logic [7:0] OPC_ABR_FLOAT   = 8'hA8;
  localparam logic [7:0] OPC_FETCH       = 8'hD0;
  localparam int         ACT_BIT         = 3;
  localparam int         DIR_BIT         = 0;

  // ****************************************************************
  // speeds, frame and status layout
  // ****************************************************************
  localparam logic [15:0] LEAVE_FLOOR_SPS = 16'h0005;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic [1:0]  TX_FRAMES       = 2'h2;
  localparam int          ST_BRIDGES_OFF  = 0;
  localparam int          ST_BUSY_N       = 1;
  localparam int          ST_SWITCH       = 2;
  localparam int          ST_REJECTED     = 3;
  localparam int          ST_ENGINE_LSB   = 4;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam logic [3:0]  OFS_CONFIG      = 4'h0;
  localparam logic [3:0]  OFS_DECEL       = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h8;
  localparam logic [3:0]  OFS_MARK        = 4'hC;
  localparam int          CFG_LOWOPT_BIT  = 16;
  localparam logic [15:0] RST_MIN_SPEED   = 16'h0000;
  localparam logic [11:0] RST_DECEL       = 12'h08A;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [5:0] {
    SS_IDLE       = 6'b000001,
    SS_LEAVE      = 6'b000010,
    SS_LEAVE_STOP = 6'b000100,
    SS_SEEK       = 6'b001000,
    SS_HALT       = 6'b010000,
    SS_FLOAT_WAIT = 6'b100000
  } sshcd_state_e;

endpackage

// File: rtl/sshcd_top.sv
// Notes on behaviour
// - leave-switch opcode runs at minimum speed, direction from bit 0
// - switch opening: clear or mark position per action bit, then abrupt halt
// - leave-switch speed is 5 step/s if minimum is lower or optimisation on
// - busy low from leave-switch start until switch open and motor stopped
// - return-to-zero seeks position zero; busy until reached
// - return-to-zero while busy is dropped and flags rejection
// - go-to-marked seeks marked position; busy until reached
// - go-to-marked while busy is dropped and flags rejection
// - clear-position opcode zeroes absolute position
// - full reinit returns all state except the pin synchronisers to power-up, only while bridges float
// - after power-up or reinit the bridges stay disabled
// - ramped halt decelerates at the configured rate then stops
// - either halt while floating re-enables bridges without motion
// - abrupt halt stops the motor at once
// - ramped float decelerates, then disables bridges and raises off flag
// - float commands with motor stopped float the bridges at once
// - abrupt float disables bridges at once and raises off flag
// - halt and float commands are taken in any state, never rejected
// - halt and float commands keep busy until the motor stops
// - fetch returns 16-bit status, high byte first, in next two frames
// - fetch clears warnings and error state, keeps bridges-off flag
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
module sshcd_top
  import sshcd_pkg::*;
#(
  parameter int POS_W = 22
) (
  input  wire logic             core_clk,      // system clock
  input  wire logic             reset_n,       // sync reset, active low
  input  wire logic             spiSck,        // link clock pin
  input  wire logic             spiCsN,        // frame select, active low
  input  wire logic             spiMosi,       // host to device data
  output logic                  spiMiso,       // device to host data
  output logic                  spiMisoOe,     // miso driven
  input  wire logic             limitSwitchIn, // limit_switch_input, high = closed
  input  wire logic             motorStopped,  // engine: speed is zero
  input  wire logic             engineBusy,    // engine: other motion busy
  input  wire logic [POS_W-1:0] absPosition,   // absolute_position value
  input  wire logic [11:0]      engineFlags,   // engine warning/error flags
  output logic                  busyN,         // busy, active low
  output logic                  bridgesOffFlag,// bridges_off_flag
  output logic                  rejectedFlag,  // rejected-command flag
  output logic                  runMinReq,     // pulse: run at leaveSpeed
  output logic                  runDir,        // 1 forward, 0 reverse
  output logic [15:0]           leaveSpeed,    // step/s for leave move
  output logic                  seekReq,       // pulse: seek seekTarget
  output logic [POS_W-1:0]      seekTarget,    // seek destination
  output logic                  rampStopReq,   // pulse: ramped stop
  output logic                  abruptStopReq, // pulse: immediate stop
  output logic [11:0]           decelRate,     // deceleration_rate
  output logic                  clearPosReq,   // pulse: zero position
  output logic                  warnClearReq,  // pulse: clear warnings/errors
  output logic                  reinitReq,     // pulse: full reinit
  output logic [POS_W-1:0]      markedPosition,// marked_position
  input  wire logic             s_axi_awvalid, // axi write address valid
  output logic                  s_axi_awready, // axi write address ready
  input  wire logic [3:0]       s_axi_awaddr,  // axi write address
  input  wire logic             s_axi_wvalid,  // axi write data valid
  output logic                  s_axi_wready,  // axi write data ready
  input  wire logic [31:0]      s_axi_wdata,   // axi write data
  input  wire logic [3:0]       s_axi_wstrb,   // axi byte strobes
  output logic                  s_axi_bvalid,  // axi write response valid
  input  wire logic             s_axi_bready,  // axi write response ready
  output logic [1:0]            s_axi_bresp,   // axi write response
  input  wire logic             s_axi_arvalid, // axi read address valid
  output logic                  s_axi_arready, // axi read address ready
  input  wire logic [3:0]       s_axi_araddr,  // axi read address
  output logic                  s_axi_rvalid,  // axi read data valid
  input  wire logic             s_axi_rready,  // axi read data ready
  output logic [31:0]           s_axi_rdata,   // axi read data
  output logic [1:0]            s_axi_rresp    // axi read response
);

  // ****************************************************************
  // reset: power-up or accepted full reinit
  // ****************************************************************
  logic clrAll;
  assign clrAll = !reset_n || reinitReq;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic sckS1, sckS2, sckS3, csS1, csS2, csS3, mosiS1, mosiS2, swS1, swS2;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      {sckS1, sckS2, sckS3} <= 3'h7;
      {csS1, csS2, csS3}    <= 3'h7;
      {mosiS1, mosiS2}      <= 2'h0;
      {swS1, swS2}          <= 2'h0;
    end else begin
      {sckS1, sckS2, sckS3} <= {spiSck, sckS1, sckS2};
      {csS1, csS2, csS3}    <= {spiCsN, csS1, csS2};
      {mosiS1, mosiS2}      <= {spiMosi, mosiS1};
      {swS1, swS2}          <= {limitSwitchIn, swS1};
    end
  end

  logic sckRise, sckFall, csFall;
  assign sckRise = sckS2 && !sckS3;
  assign sckFall = !sckS2 && sckS3;
  assign csFall  = !csS2 && csS3;

  // ****************************************************************
  // byte framing and status return
  // ****************************************************************
  logic [7:0]  rxShift_reg, txShift_reg, cmdByte_reg;
  logic [2:0]  bitCnt_reg;
  logic        cmdValid_reg, txFrame_reg;
  logic [1:0]  txLeft_reg;
  logic [15:0] statusSnap_reg, statusWord;
  logic        fetchNow;

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      rxShift_reg  <= 8'h00;
      bitCnt_reg   <= 3'h0;
      cmdByte_reg  <= 8'h00;
      cmdValid_reg <= 1'b0;
    end else begin
      cmdValid_reg <= 1'b0;
      if (csS2) begin
        bitCnt_reg <= 3'h0;
      end else if (sckRise) begin
        rxShift_reg <= {rxShift_reg[6:0], mosiS2};
        bitCnt_reg  <= bitCnt_reg + 3'h1;
        if (bitCnt_reg == BIT_LAST && !txFrame_reg) begin
          cmdByte_reg  <= {rxShift_reg[6:0], mosiS2};
          cmdValid_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      txShift_reg    <= 8'h00;
      txLeft_reg     <= 2'h0;
      txFrame_reg    <= 1'b0;
      statusSnap_reg <= 16'h0000;
    end else if (fetchNow) begin
      statusSnap_reg <= statusWord;
      txLeft_reg     <= TX_FRAMES;
    end else if (csFall) begin
      txFrame_reg <= (txLeft_reg != 2'h0);
      if (txLeft_reg == TX_FRAMES) begin
        txShift_reg <= statusSnap_reg[15:8];
      end else if (txLeft_reg != 2'h0) begin
        txShift_reg <= statusSnap_reg[7:0];
      end else begin
        txShift_reg <= 8'h00;
      end
      if (txLeft_reg != 2'h0) txLeft_reg <= txLeft_reg - 2'h1;
    end else if (!csS2 && sckFall && bitCnt_reg != 3'h0) begin // first fall keeps bit 7
      txShift_reg <= {txShift_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      spiMiso   <= 1'b0;
      spiMisoOe <= 1'b0;
    end else begin
      spiMiso   <= !csS2 && txShift_reg[7]; // idle low outside a frame
      spiMisoOe <= !csS2;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [15:0] minSpeed_reg;
  logic        lowOpt_reg;
  logic        wrEn;
  logic [3:0]  wrAddr_reg;
  logic [31:0] wrData_reg;
  logic [3:0]  wrStrb_reg;

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      minSpeed_reg <= RST_MIN_SPEED;
      lowOpt_reg   <= 1'b0;
      decelRate    <= RST_DECEL;
    end else if (wrEn && wrAddr_reg == OFS_CONFIG) begin
      if (wrStrb_reg[0]) minSpeed_reg[7:0]  <= wrData_reg[7:0];
      if (wrStrb_reg[1]) minSpeed_reg[15:8] <= wrData_reg[15:8];
      if (wrStrb_reg[2]) lowOpt_reg         <= wrData_reg[CFG_LOWOPT_BIT];
    end else if (wrEn && wrAddr_reg == OFS_DECEL) begin
      if (wrStrb_reg[0]) decelRate[7:0]  <= wrData_reg[7:0];
      if (wrStrb_reg[1]) decelRate[11:8] <= wrData_reg[11:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll || minSpeed_reg < LEAVE_FLOOR_SPS || lowOpt_reg) begin
      leaveSpeed <= LEAVE_FLOOR_SPS;
    end else begin
      leaveSpeed <= minSpeed_reg;
    end
  end

  // ****************************************************************
  // command sequencing
  // ****************************************************************
  sshcd_state_e state_reg;
  logic         actSel_reg, busyNow, rejectNow;
  logic [7:0]   op;

  assign op        = cmdByte_reg;
  assign busyNow   = !busyN;
  assign fetchNow  = cmdValid_reg && op == OPC_FETCH;
  assign rejectNow = cmdValid_reg && busyNow && (op == OPC_RET_ZERO || op == OPC_GO_MARK);

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      state_reg      <= SS_IDLE;
      actSel_reg     <= 1'b0;
      runMinReq      <= 1'b0;
      runDir         <= 1'b0;
      seekReq        <= 1'b0;
      seekTarget     <= '0;
      rampStopReq    <= 1'b0;
      abruptStopReq  <= 1'b0;
      clearPosReq    <= 1'b0;
      bridgesOffFlag <= 1'b1;
      markedPosition <= '0;
    end else begin
      runMinReq     <= 1'b0;
      seekReq       <= 1'b0;
      rampStopReq   <= 1'b0;
      abruptStopReq <= 1'b0;
      clearPosReq   <= 1'b0;
      // halt and float take priority over any sequence in progress
      if (cmdValid_reg && (op == OPC_RAMP_HALT || op == OPC_ABR_HALT)) begin
        if (bridgesOffFlag) begin
          bridgesOffFlag <= 1'b0;
          state_reg      <= SS_IDLE;
        end else begin
          rampStopReq   <= (op == OPC_RAMP_HALT);
          abruptStopReq <= (op == OPC_ABR_HALT);
          state_reg     <= SS_HALT;
        end
      end else if (cmdValid_reg && op == OPC_RAMP_FLOAT) begin
        if (motorStopped) begin
          bridgesOffFlag <= 1'b1;
          state_reg      <= SS_IDLE;
        end else begin
          rampStopReq <= 1'b1;
          state_reg   <= SS_FLOAT_WAIT;
        end
      end else if (cmdValid_reg && op == OPC_ABR_FLOAT) begin
        bridgesOffFlag <= 1'b1;
        abruptStopReq  <= !motorStopped;
        state_reg      <= motorStopped ? SS_IDLE : SS_HALT;
      end else if (cmdValid_reg && (op & OPC_LEAVE_MASK) == OPC_LEAVE_BASE) begin
        runMinReq      <= 1'b1;
        runDir         <= op[DIR_BIT];
        actSel_reg     <= op[ACT_BIT];
        bridgesOffFlag <= 1'b0;
        state_reg      <= SS_LEAVE;
      end else if (cmdValid_reg && op == OPC_RET_ZERO && !busyNow) begin
        seekReq        <= 1'b1;
        seekTarget     <= '0;
        bridgesOffFlag <= 1'b0;
        state_reg      <= SS_SEEK;
      end else if (cmdValid_reg && op == OPC_GO_MARK && !busyNow) begin
        seekReq        <= 1'b1;
        seekTarget     <= markedPosition;
        bridgesOffFlag <= 1'b0;
        state_reg      <= SS_SEEK;
      end else begin
        if (cmdValid_reg && op == OPC_CLEAR_POS) clearPosReq <= 1'b1;
        case (state_reg)
          SS_IDLE: state_reg <= SS_IDLE;
          SS_LEAVE: begin
            if (!swS2) begin
              if (actSel_reg) begin
                markedPosition <= absPosition;
              end else begin
                clearPosReq <= 1'b1;
              end
              abruptStopReq <= 1'b1;
              state_reg     <= SS_LEAVE_STOP;
            end
          end
          SS_LEAVE_STOP: if (motorStopped) state_reg <= SS_IDLE;
          SS_SEEK: if (motorStopped && absPosition == seekTarget) state_reg <= SS_IDLE;
          SS_HALT: if (motorStopped) state_reg <= SS_IDLE;
          SS_FLOAT_WAIT: begin
            if (motorStopped) begin
              bridgesOffFlag <= 1'b1;
              state_reg      <= SS_IDLE;
            end
          end
          default: state_reg <= SS_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // busy, flags and side-effect pulses
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      busyN        <= 1'b1;
      rejectedFlag <= 1'b0;
      warnClearReq <= 1'b0;
    end else begin
      // busy lags the state by one cycle; commands see the registered level
      busyN        <= (state_reg == SS_IDLE) && !engineBusy;
      rejectedFlag <= rejectNow || (rejectedFlag && !fetchNow);
      warnClearReq <= fetchNow;
    end
  end

  // reinit pulse must survive its own effect, so only power-up clears it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reinitReq <= 1'b0;
    end else begin
      reinitReq <= cmdValid_reg && op == OPC_REINIT && bridgesOffFlag && !reinitReq;
    end
  end

  always_comb begin
    statusWord = 16'h0000;
    statusWord[ST_BRIDGES_OFF] = bridgesOffFlag;
    statusWord[ST_BUSY_N]      = busyN;
    statusWord[ST_SWITCH]      = swS2;
    statusWord[ST_REJECTED]    = rejectedFlag;
    statusWord[15:ST_ENGINE_LSB] = engineFlags;
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign wrEn = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wrAddr_reg   <= 4'h0;
      wrData_reg   <= 32'h00000000;
      wrStrb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wrAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wrData_reg <= s_axi_wdata;
        wrStrb_reg <= s_axi_wstrb;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrAddr_reg == OFS_CONFIG || wrAddr_reg == OFS_DECEL) ?
                        RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clrAll) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_CONFIG: s_axi_rdata <= {15'h0000, lowOpt_reg, minSpeed_reg};
        OFS_DECEL:  s_axi_rdata <= {20'h00000, decelRate};
        OFS_STATUS: s_axi_rdata <= {10'h000, state_reg, statusWord};
        OFS_MARK:   s_axi_rdata <= {{(32-POS_W){1'b0}}, markedPosition};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: sim/sshcd_checker.sv
module sshcd_checker (
  input wire logic        core_clk,       // clock
  input wire logic        reset_n,        // sync reset
  input wire logic        spiMiso,        // device data
  input wire logic        spiMisoOe,      // data driven
  input wire logic        motorStopped,   // engine stopped
  input wire logic        busyN,          // busy, low
  input wire logic        bridgesOffFlag, // floating
  input wire logic        rejectedFlag,   // rejected
  input wire logic        runMinReq,      // leave start
  input wire logic [15:0] leaveSpeed,     // leave speed
  input wire logic        seekReq,        // seek start
  input wire logic        rampStopReq,    // ramped stop
  input wire logic        abruptStopReq,  // abrupt stop
  input wire logic        reinitReq       // reinit pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************
  // port relations
  // ************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_RUN_BUSY: assert property (runMinReq |-> ##[0:2] !busyN)
    else $error("leave move started without busy");
  AST_LEAVE_SPD: assert property (runMinReq |=> leaveSpeed >= 16'h0005)
    else $error("leave speed below floor");
  AST_SEEK_BUSY: assert property (seekReq |-> ##[0:2] !busyN)
    else $error("seek started without busy");
  AST_REINIT_GUARD: assert property (reinitReq |-> bridgesOffFlag)
    else $error("reinit taken with bridges on");
  AST_REINIT_OFF: assert property (reinitReq |-> ##2 (bridgesOffFlag && busyN))
    else $error("bridges not off after reinit");
  // busy lags one cycle, so judge it the cycle after the motor is seen moving
  AST_STOP_BUSY: assert property ((rampStopReq || abruptStopReq) ##1 !motorStopped |=> !busyN)
    else $error("busy released while stopping");
  AST_REJ_BUSY: assert property ($rose(rejectedFlag) |-> !$past(busyN))
    else $error("rejection while not busy");
  AST_MISO_IDLE: assert property (!spiMisoOe |-> !spiMiso)
    else $error("data line active outside frame");
  cover property (seekReq);
  cover property ($rose(rejectedFlag));
  cover property (reinitReq);
endmodule

bind sshcd_top sshcd_checker chk (.core_clk, .reset_n, .spiMiso, .spiMisoOe, .motorStopped,
  .busyN, .bridgesOffFlag, .rejectedFlag, .runMinReq, .leaveSpeed, .seekReq, .rampStopReq,
  .abruptStopReq, .reinitReq);

// File: sim/sshcd_host.sv
module sshcd_host (
  output logic      spiSck,  // link clock, idle high
  output logic      spiCsN,  // frame select
  output logic      spiMosi, // host data
  input  wire logic spiMiso  // device data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spiSck = 1'b1;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // ************************************************
  // mode 3 byte frame; sck stands high between frames
  // ************************************************
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #13;
    spiCsN = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      spiSck = 1'b0;
      spiMosi = tx[i];
      #200;
      spiSck = 1'b1;
      rx[i] = spiMiso;
      #200;
    end
    #200;
    spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    #400;
  endtask
endmodule

// File: sim/tb_top.sv
`define CK(a, e) begin samplesChecked++; if ((a) !== (e)) begin nMismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sshcd_pkg::*;
  logic        core_clk, reset_n, spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe, limitSwitchIn;
  logic        motorStopped, engineBusy, busyN, bridgesOffFlag, rejectedFlag, runMinReq;
  logic        runDir, seekReq, rampStopReq, abruptStopReq, clearPosReq, warnClearReq;
  logic        reinitReq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [21:0] absPosition, seekTarget, markedPosition;
  logic [11:0] engineFlags, decelRate;
  logic [15:0] leaveSpeed;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  pv;
  logic [7:0]  rx;
  int          nMismatch, samplesChecked, pc[7];
  sshcd_top dut (.core_clk, .reset_n, .spiSck, .spiCsN, .spiMosi, .spiMiso, .spiMisoOe,
    .limitSwitchIn, .motorStopped, .engineBusy, .absPosition, .engineFlags, .busyN,
    .bridgesOffFlag, .rejectedFlag, .runMinReq, .runDir, .leaveSpeed, .seekReq, .seekTarget,
    .rampStopReq, .abruptStopReq, .decelRate, .clearPosReq, .warnClearReq, .reinitReq,
    .markedPosition, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  sshcd_host host (.spiSck, .spiCsN, .spiMosi, .spiMiso);
  // ************************************************
  // engine stand-in: counts pulses, zeroes position
  // ************************************************
  assign pv = {reinitReq, warnClearReq, clearPosReq, abruptStopReq, rampStopReq, seekReq,
               runMinReq};
  always @(posedge core_clk) begin
    for (int i = 0; i < 7; i++) pc[i] <= pc[i] + 32'(pv[i]);
    if (clearPosReq === 1'b1) absPosition <= '0;
  end
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ************************************************
  // drivers
  // ************************************************
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.xfer(op, rx);
    w(4);
  endtask
  task automatic eng(input logic s, input logic [21:0] p, input logic l);
    @(posedge core_clk);
    motorStopped <= s;
    absPosition <= p;
    limitSwitchIn <= l;
    w(8);
  endtask
  // ready is sampled at the falling edge: it settles there and holds through the rise
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    tb = 1'b0;
    while (!tb) begin
      @(negedge core_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CK(r, er)
  endtask
  task automatic axiRd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    tr = 1'b0;
    while (!tr) begin
      @(negedge core_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CK(d, ed)
    `CK(r, er)
  endtask
  task automatic conclude();
    if (nMismatch == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic tReset();
    `CK(bridgesOffFlag, 1'b1)
    `CK(spiMisoOe, 1'b0)
    axiRd(OFS_DECEL, {20'h0, RST_DECEL}, RESP_OKAY);
    axiRd(4'h2, 32'h0, RESP_SLVERR);
    axiWr(OFS_STATUS, 32'h0000FFFF, RESP_SLVERR);
  endtask
  task automatic tLeave();
    axiWr(OFS_CONFIG, 32'h00000003, RESP_OKAY);
    eng(1'b1, 22'h123, 1'b1);
    cmd(8'h9B);
    `CK(runDir, 1'b1)
    `CK(leaveSpeed, 16'h0005)
    `CK(busyN, 1'b0)
    eng(1'b0, 22'h123, 1'b0);
    `CK(markedPosition, 22'h123)
    `CK(pc[3], 1)
    `CK(busyN, 1'b0)
    eng(1'b1, 22'h123, 1'b0);
    `CK(busyN, 1'b1)
    axiWr(OFS_CONFIG, 32'h0001000A, RESP_OKAY);
    eng(1'b1, 22'h123, 1'b1);
    cmd(8'h92);
    `CK(runDir, 1'b0)
    `CK(leaveSpeed, 16'h0005)
    eng(1'b1, 22'h123, 1'b0);
    `CK(pc[4], 1)
    `CK(pc[0], 2)
    axiWr(OFS_CONFIG, 32'h0000000A, RESP_OKAY);
    w(1);
    `CK(leaveSpeed, 16'h000A)
  endtask
  task automatic tSeek();
    eng(1'b0, 22'h40, 1'b0);
    cmd(OPC_RET_ZERO);
    `CK(seekTarget, 22'h0)
    cmd(OPC_GO_MARK);
    `CK(rejectedFlag, 1'b1)
    `CK(pc[1], 1)
    eng(1'b1, 22'h40, 1'b0);
    `CK(busyN, 1'b0)
    eng(1'b1, 22'h0, 1'b0);
    `CK(busyN, 1'b1)
    eng(1'b0, 22'h7, 1'b0);
    cmd(OPC_GO_MARK);
    `CK(seekTarget, 22'h123)
    cmd(OPC_RET_ZERO);
    `CK(pc[1], 2)
    eng(1'b1, 22'h123, 1'b0);
    `CK(busyN, 1'b1)
  endtask
  task automatic tFetch();
    @(posedge core_clk);
    engineFlags <= 12'hA5C;
    host.xfer(OPC_FETCH, rx);
    `CK(rx, 8'h00)
    w(4);
    `CK(rejectedFlag, 1'b0)
    `CK(pc[5], 1)
    host.xfer(8'h00, rx);
    `CK(rx, 8'hA5)
    host.xfer(8'h00, rx);
    host.xfer(OPC_FETCH, rx);
    host.xfer(8'h00, rx);
    host.xfer(8'h00, rx);
    `CK(rx, 8'hC2)
    host.xfer(8'h00, rx);
    `CK(rx, 8'h00)
  endtask
  task automatic tStops();
    eng(1'b0, 22'h0, 1'b0);
    cmd(OPC_RAMP_HALT);
    `CK(pc[2], 1)
    cmd(OPC_ABR_HALT);
    `CK(pc[3], 3)
    cmd(OPC_RAMP_FLOAT);
    `CK(bridgesOffFlag, 1'b0)
    eng(1'b1, 22'h0, 1'b0);
    `CK(bridgesOffFlag, 1'b1)
    cmd(OPC_ABR_HALT);
    `CK(bridgesOffFlag, 1'b0)
    cmd(OPC_RAMP_FLOAT);
    `CK(bridgesOffFlag, 1'b1)
    cmd(OPC_FETCH);
    `CK(bridgesOffFlag, 1'b1)
    host.xfer(8'h00, rx);
    host.xfer(8'h00, rx);
    `CK(rx, 8'hC3)
    cmd(OPC_RAMP_HALT);
    `CK(pc[2], 2)
    eng(1'b0, 22'h0, 1'b0);
    cmd(OPC_ABR_FLOAT);
    `CK(bridgesOffFlag, 1'b1)
    `CK(busyN, 1'b0)
    eng(1'b1, 22'h0, 1'b0);
  endtask
  task automatic tReinit();
    cmd(OPC_ABR_HALT);
    axiWr(OFS_DECEL, 32'h00000123, RESP_OKAY);
    `CK(decelRate, 12'h123)
    cmd(OPC_REINIT);
    `CK(pc[6], 0)
    cmd(OPC_CLEAR_POS);
    `CK(pc[4], 2)
    cmd(OPC_ABR_FLOAT);
    cmd(OPC_REINIT);
    `CK(pc[6], 1)
    axiRd(OFS_DECEL, {20'h0, RST_DECEL}, RESP_OKAY);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
     s_axi_araddr, s_axi_wstrb, s_axi_wdata, limitSwitchIn, engineBusy, absPosition,
     engineFlags, reset_n} = '0;
    motorStopped = 1'b1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    w(4);
    tReset();
    tLeave();
    tSeek();
    tFetch();
    tStops();
    tReinit();
    conclude();
  end
  // whole run needs well under half of this span
  initial begin
    #2000000;
    nMismatch++;
    conclude();
  end
endmodule
